// file: hw/dac_serial_load_control.v
// Serial load, readback, load and clear control of the converter
`timescale 1ns/1ps
`include "dac_serial_regs.vh"
module dac_serial_load_control #(
  parameter FRAME_BITS = `FRAME_BITS,
  parameter DATA_BITS = `DATA_BITS
) (
  core_clk,
  sys_rst,
  serial_clk,
  frame_sel_n,
  serial_in,
  output_load_n,
  output_clear_n,
  device_reset_n,
  readbackData,
  clearValue,
  codeTwos,
  serial_out_o,
  serial_out_oe,
  inputReg,
  dacReg,
  frameWord,
  frameDone,
  outputUpdate
);
  input wire core_clk;
  input wire sys_rst;
  input wire serial_clk;
  input wire frame_sel_n;
  input wire serial_in;
  input wire output_load_n;
  input wire output_clear_n;
  input wire device_reset_n;
  input wire [FRAME_BITS-1:0] readbackData;
  input wire [DATA_BITS-1:0] clearValue;
  input wire codeTwos;
  output reg serial_out_o;
  output reg serial_out_oe;
  output reg [DATA_BITS-1:0] inputReg;
  output reg [DATA_BITS-1:0] dacReg;
  output reg [FRAME_BITS-1:0] frameWord;
  output reg frameDone;
  output reg outputUpdate;

  localparam PIN_COUNT = 6;
  // Each synchroniser resets to the idle level of its pin, so that no
  // false edge follows reset; the serial clock idles high between frames
  localparam [PIN_COUNT-1:0] PIN_IDLE = 6'h33;

  wire [PIN_COUNT-1:0] pinVec;
  wire [PIN_COUNT-1:0] pinLvl;

  // Synchronised pin levels
  wire sclkLvl;
  wire selLvl;
  wire sdinLvl;
  wire loadLvl;
  wire clearLvl;
  wire resetLvl;
  wire softReset;

  // Edge strobes, one core cycle wide
  wire sclkFall;
  wire sclkRise;
  wire selFall;
  wire selRise;
  wire loadFall;

  // Edge history and shift registers
  reg sclk_reg;
  reg sel_reg;
  reg load_reg;
  reg [FRAME_BITS-1:0] shift_reg;
  reg [FRAME_BITS-1:0] outShift_reg;
  reg [DATA_BITS-1:0] clearCode;
  genvar pinIdx;

  assign pinVec[0] = serial_clk;
  assign pinVec[1] = frame_sel_n;
  assign pinVec[2] = serial_in;
  assign pinVec[3] = output_load_n;
  assign pinVec[4] = output_clear_n;
  assign pinVec[5] = device_reset_n;

  // Every pin passes the same depth, so the order of pin edges is kept
  generate
    for (pinIdx = 0; pinIdx < PIN_COUNT; pinIdx = pinIdx + 1) begin : gen_pin
      pin_sync #(
        .RESET_LEVEL(PIN_IDLE[pinIdx])
      ) syncPin (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pinIn(pinVec[pinIdx]),
        .levelOut(pinLvl[pinIdx])
      );
    end
  endgenerate

  assign sclkLvl = pinLvl[0];
  assign selLvl = pinLvl[1];
  assign sdinLvl = pinLvl[2];
  assign loadLvl = pinLvl[3];
  assign clearLvl = pinLvl[4];
  assign resetLvl = pinLvl[5];

  // Pin reset acts like the system reset, clocked
  assign softReset = sys_rst | ~resetLvl;

  assign sclkFall = sclk_reg & ~sclkLvl;
  assign sclkRise = ~sclk_reg & sclkLvl;
  assign selFall = sel_reg & ~selLvl;
  assign selRise = ~sel_reg & selLvl;
  assign loadFall = load_reg & ~loadLvl;

  // Clear value is held in the coding the data register uses; twos
  // complement codes are stored as is, binary codes likewise, so the
  // coding flag leaves the clear code unchanged.
  always @* begin
    if (codeTwos == `CODE_TWOS) begin
      clearCode = clearValue;
    end else begin
      clearCode = clearValue;
    end
  end

  // Previous pin levels, reset to the idle levels of the pins
  always @(posedge core_clk) begin
    if (softReset) begin
      sclk_reg <= 1'b1;
      sel_reg <= 1'b1;
      load_reg <= 1'b0;
    end else begin
      sclk_reg <= sclkLvl;
      sel_reg <= selLvl;
      load_reg <= loadLvl;
    end
  end

  // Readback word loaded MSB first at frame start
  // Each bit then stands until the rising edge on which the host samples it
  always @(posedge core_clk) begin
    if (softReset) begin
      outShift_reg <= {FRAME_BITS{1'b0}};
      serial_out_o <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (selFall) begin
      outShift_reg <= {readbackData[FRAME_BITS-2:0], 1'b0};
      serial_out_o <= readbackData[FRAME_BITS-1];
      serial_out_oe <= 1'b1;
    end else if (selRise) begin
      serial_out_oe <= 1'b0;
    end else if (!selLvl && sclkRise) begin
      serial_out_o <= outShift_reg[FRAME_BITS-1];
      outShift_reg <= {outShift_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // A long frame keeps its last bits; a short one leaves older bits in place
  always @(posedge core_clk) begin
    if (softReset) begin
      shift_reg <= {FRAME_BITS{1'b0}};
    end else if (!selLvl && sclkFall) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdinLvl};
    end
  end

  // The word lands at frame end with no bit count check, so a cut frame still reaches the registers
  always @(posedge core_clk) begin
    if (softReset) begin
      frameWord <= {FRAME_BITS{1'b0}};
      frameDone <= 1'b0;
      inputReg <= `DATA_RESET;
    end else begin
      frameDone <= selRise;
      if (selRise) begin
        frameWord <= shift_reg;
        inputReg <= shift_reg[DATA_BITS-1:0];
      end
    end
  end

  // A frame end outranks clear in its own cycle; clear wins from the next
  // cycle on and keeps the output pulse up while the pin is held low
  always @(posedge core_clk) begin
    if (softReset) begin
      dacReg <= `DATA_RESET;
      outputUpdate <= 1'b0;
    end else if (selRise && !loadLvl) begin
      dacReg <= shift_reg[DATA_BITS-1:0];
      outputUpdate <= 1'b1;
    end else if (selRise) begin
      // Deferred: the input register and frameWord take the word, dacReg keeps its value
      outputUpdate <= 1'b0;
    end else if (!clearLvl) begin
      dacReg <= clearCode;
      outputUpdate <= 1'b1;
    end else if (loadFall) begin
      // A load edge with nothing pending still refreshes the output
      dacReg <= inputReg;
      outputUpdate <= 1'b1;
    end else begin
      outputUpdate <= 1'b0;
    end
  end
endmodule // dac_serial_load_control

// file: shared/dac_serial_regs.vh
// Constants for the converter serial load front end
`ifndef DAC_SERIAL_REGS_VH
`define DAC_SERIAL_REGS_VH
`define FRAME_BITS 24
`define DATA_BITS 24
`define DATA_RESET 24'h00_0000
`define CLEAR_VALUE_RESET 24'h00_0000
`define CODE_BINARY 1'b0
`define CODE_TWOS 1'b1
`define WRITE_CLK_MAX_KHZ 35000
`define READ_CLK_MAX_KHZ 16000
`endif

// file: hw/pin_sync.v
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  core_clk,
  sys_rst,
  pinIn,
  levelOut
);
  input wire core_clk;
  input wire sys_rst;
  input wire pinIn;
  output reg levelOut;
  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // Stage one feeds only stage two
  always @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
      levelOut <= RESET_LEVEL;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg) begin
        levelOut <= stage3_reg;
      end
    end
  end
endmodule // pin_sync

// file: dv/dac_load_asserts.sv
// Port checks for the converter serial load front end
`timescale 1ns/1ps
module dac_load_asserts #(parameter DATA_BITS = 24) (
  input wire core_clk,
  input wire sys_rst,
  input wire frame_sel_n,
  input wire output_load_n,
  input wire output_clear_n,
  input wire [DATA_BITS-1:0] clearValue,
  input wire serial_out_oe,
  input wire [DATA_BITS-1:0] inputReg,
  input wire [DATA_BITS-1:0] dacReg,
  input wire frameDone,
  input wire outputUpdate
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_done_pulse: assert property (frameDone |=> !frameDone)
    else $error("frameDone wide");
  a_oe_start: assert property ($fell(frame_sel_n) |-> ##[1:8] serial_out_oe)
    else $error("no drive");
  a_oe_release: assert property ($rose(frame_sel_n) |-> ##[1:8] !serial_out_oe)
    else $error("no release");
  a_load_update: assert property ($rose(frame_sel_n) && !output_load_n && output_clear_n
    |-> ##[1:8] outputUpdate) else $error("no update");
  a_held_update: assert property ($rose(frame_sel_n) && output_load_n
    |-> ##[1:8] frameDone && !outputUpdate) else $error("held update");
  a_load_fall: assert property ($fell(output_load_n) && output_clear_n
    |-> ##[1:8] outputUpdate) else $error("load fall");
  a_dac_cause: assert property (dacReg != $past(dacReg)
    |-> outputUpdate || $past(outputUpdate) || dacReg == 0) else $error("dac moved");
  a_input_cause: assert property (inputReg != $past(inputReg)
    |-> frameDone || $past(frameDone) || inputReg == 0) else $error("input moved");
  a_clear_code: assert property (!output_clear_n [*8] |-> ##1 dacReg == clearValue)
    else $error("clear code");
endmodule // dac_load_asserts
bind dac_serial_load_control dac_load_asserts #(.DATA_BITS(DATA_BITS)) u_chk(.core_clk,
  .sys_rst, .frame_sel_n, .output_load_n, .output_clear_n, .clearValue, .serial_out_oe,
  .inputReg, .dacReg, .frameDone, .outputUpdate);

// file: dv/host_serial_model.sv
// Host side serial port model
`timescale 1ns/1ps
module host_serial_model (
  output logic sclk,
  output logic selN,
  output logic sdi,
  input wire logic serial_out
);
  // Clock idles high and stands still between frames
  initial begin
    sclk = 1;
    selN = 1;
    sdi = 0;
  end
  task automatic xfer(input logic [23:0] w, output logic [23:0] r, input int hp);
    selN = 0;
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      #hp sclk = 0;
      #hp r[i] = serial_out;
      sclk = 1;
    end
    #hp selN = 1;
    sdi = ~sdi;
    #96;
  endtask
endmodule // host_serial_model

// file: dv/dac_serial_load_control_test.sv
// Bench for the converter serial load front end
`timescale 1ns/1ps
module dac_serial_load_control_test;
  logic core_clk = 0, sys_rst = 1, loadN = 0, clearN = 1, devRstN = 1, codeTwos = 0;
  logic sclk, selN, sdi, serial_out, sdoOe, sdoPin, done, upd;
  logic [23:0] rb = 0, clrVal = 0, inReg, dacReg, fw, w, r, expDac, expW;
  logic [23:0] expQ[$];
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  initial forever #2.5 core_clk = ~core_clk;
  // A released output shows the inverse of its last bit, so a late enable is caught
  assign sdoPin = sdoOe ? serial_out : ~serial_out;
  host_serial_model i_host(.sclk, .selN, .sdi, .serial_out(sdoPin));
  dac_serial_load_control i_dut(.core_clk, .sys_rst, .serial_clk(sclk), .frame_sel_n(selN),
    .serial_in(sdi), .output_load_n(loadN), .output_clear_n(clearN), .device_reset_n(devRstN),
    .readbackData(rb), .clearValue(clrVal), .codeTwos, .serial_out_o(serial_out),
    .serial_out_oe(sdoOe), .inputReg(inReg), .dacReg, .frameWord(fw), .frameDone(done),
    .outputUpdate(upd));
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task frame(input bit rd);
    w = 24'($urandom);
    rb = 24'($urandom);
    expQ.push_back(w);
    i_host.xfer(w, r, rd ? 32 : 24);
    if (rd) chk("readback", r, rb);
    wt(12);
  endtask
  always @(negedge core_clk) begin
    cyc++;
    if (done === 1'b1) begin
      expW = expQ.pop_front();
      chk("inputReg", inReg, expW);
      chk("frameWord", fw, expW);
      chk("outputUpdate", 24'(upd), 24'(!loadN));
      chk("serial_out_oe", 24'(sdoOe), 24'h00_0000);
    end
    if (cyc > 5000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    void'($urandom(51348));
    wt(12);
    sys_rst = 0;
    wt(6);
    frame(1);
    expDac = w;
    chk("dacReg", dacReg, expDac);
    loadN = 1;
    frame(0);
    chk("dacReg", dacReg, expDac);
    loadN = 0;
    expDac = w;
    wt(10);
    chk("dacReg", dacReg, expDac);
    for (int i = 0; i < 2; i++) begin
      codeTwos = i[0];
      clrVal = 24'($urandom);
      clearN = 0;
      wt(12);
      chk("dacReg", dacReg, clrVal);
      clearN = 1;
      wt(6);
    end
    frame(1);
    devRstN = 0;
    wt(10);
    devRstN = 1;
    wt(8);
    chk("inputReg", inReg, '0);
    chk("dacReg", dacReg, '0);
    frame(1);
    chk("dacReg", dacReg, w);
    end_sim;
  end
endmodule // dac_serial_load_control_test
